/* File: pkg/ppb_pkg.sv */
// constants, register map and carriers for the pseudo-random self test
// assumes one clock domain (sys_clk) and a synchronous active-low reset
`default_nettype none

package ppb_pkg;

  // ------------------------------------------------------------
  // register map (word offsets on the management port)
  // ------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL     = 8'h16;
  localparam logic [7:0]  OFS_STATUS   = 8'h17;
  localparam logic [7:0]  OFS_PKT_LEN  = 8'h18;
  localparam logic [7:0]  OFS_GAP_LEN  = 8'h19;
  localparam logic [7:0]  OFS_CHK_CTRL = 8'h39;
  localparam logic [7:0]  OFS_BYTE_CNT = 8'h3a;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int          CTRL_GEN_LSB  = 12;   // generator field [15:12]
  localparam int          CTRL_LB_LSB   = 10;   // loopback select [11:10]
  localparam int          ST_LOCK_BIT   = 0;
  localparam int          ST_LOST_BIT   = 1;
  localparam int          ST_BUSY_BIT   = 2;
  localparam int          CHK_CLR_BIT   = 0;    // write 1: clear counters
  localparam int          CHK_EN_BIT    = 1;    // checker enable
  localparam int          CHK_ERR_LSB   = 8;    // error count [15:8]

  // ------------------------------------------------------------
  // field values and reset values
  // ------------------------------------------------------------
  localparam logic [3:0]  GEN_OFF       = 4'h0;
  localparam logic [3:0]  GEN_CONT      = 4'hf;
  localparam logic [1:0]  LB_EXTERNAL   = 2'h0;
  localparam logic [1:0]  LB_DIGITAL    = 2'h1;
  localparam logic [1:0]  LB_ANALOG     = 2'h2;
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [15:0] PKT_LEN_RST   = 16'h0040;
  localparam logic [15:0] GAP_LEN_RST   = 16'h000c;
  localparam logic [14:0] LFSR_SEED     = 15'h7fff;
  localparam logic [3:0]  LOCK_BYTES    = 4'h4;   // good bytes to lock
  localparam logic [3:0]  LOSS_ERRS     = 4'h4;   // bad bytes to drop lock

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } ppb_line_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } ppb_mreq_s;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_PKT  = 2'b01,
    GEN_GAP  = 2'b10
  } ppb_gen_e;

endpackage : ppb_pkg

`default_nettype wire

/* File: core/ppb_lfsr_step.sv */
// one byte step of the 15-bit sequence register, x^15 + x^14 + 1
// purely combinational; the caller holds the state flop
`default_nettype none

module ppb_lfsr_step #(
  parameter int W = 15
) (
  input  wire logic [W-1:0] state_in,
  input  wire logic [7:0]   din,
  input  wire logic         use_din,
  output logic      [W-1:0] state_out,
  output logic      [7:0]   dout
);

  // ------------------------------------------------------------
  // eight serial shifts, msb first; use_din makes it self-seeding
  // ------------------------------------------------------------
  always_comb
  begin
    logic [W-1:0] s;
    logic         fb;
    s    = state_in;
    fb   = 1'b0;
    dout = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      fb      = s[W-1] ^ s[W-2];
      dout[i] = fb;
      s       = {s[W-2:0], (use_din ? din[i] : fb)};
    end
    state_out = s;
  end

endmodule : ppb_lfsr_step

`default_nettype wire

/* File: core/ppb_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes depth is a power of two
`default_nettype none

module ppb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // ------------------------------------------------------------
  // pointers and fill level
  // ------------------------------------------------------------
  always_comb
  begin
    in_ready  = (cnt_q != (AW+1)'(D));  // honest full
    out_valid = (cnt_q != '0);
    out_data  = mem_q[rd_q];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
    cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset; only words below the level are read
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

endmodule : ppb_fifo

`default_nettype wire

/* File: core/ppb_bist.sv */
// pseudo-random packet generator and byte checker with its registers
// assumes a register port on sys_clk and a byte-wide line that may stall
//
// Overview of operation
// - runs over internal digital, internal analog or external cable loopback.
// - random payload goes out as packets separated by idle gaps.
// - software programs packet length and gap length.
// - generator and checker are independent; generator streams while enabled.
// - pattern comes from a fifteen-bit linear feedback shift register.
// - checker compares received bits to its own sequence for pass or fail.
// - errored received bytes are counted while locked, readable at 0x39.
// - status at 0x17 shows lock, sync loss and generator busy.
// - received bytes are counted while the checker is enabled, readable at 0x3A.
// - generator field at 0x16: 0x0 off, 0xF continuous, nothing else.
// - in continuous mode counters wrap to zero at maximum.
`default_nettype none

module ppb_bist #(
  parameter int FIFO_DEPTH = 8,
  parameter int ERR_W      = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire ppb_pkg::ppb_mreq_s mreq,
  output logic      [15:0]       mgmt_rdata,
  output logic                   mgmt_rvalid,
  output ppb_pkg::ppb_line_s     tx_line,
  input  wire logic              tx_ready,
  input  wire ppb_pkg::ppb_line_s rx_line,
  output logic      [1:0]        lb_mode
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [15:0]      ctrl_q, ctrl_d, pkt_len_q, pkt_len_d, gap_len_q, gap_len_d;
  logic             chk_en_q, chk_en_d;
  logic [15:0]      rdata_q, rdata_d;
  logic             rvalid_q, rvalid_d;
  logic [3:0]       gen_field;
  logic             cont;
  logic             clr_cnt;

  assign gen_field = ctrl_q[ppb_pkg::CTRL_GEN_LSB +: 4];
  assign cont      = (gen_field == ppb_pkg::GEN_CONT);
  assign clr_cnt   = mreq.wr && (mreq.addr == ppb_pkg::OFS_CHK_CTRL) && mreq.wdata[ppb_pkg::CHK_CLR_BIT];

  // ------------------------------------------------------------
  // generator state
  // ------------------------------------------------------------
  ppb_pkg::ppb_gen_e gst_q, gst_d;
  logic [15:0]      gcnt_q, gcnt_d;
  logic [14:0]      gen_s_q, gen_s_d, gen_s_nxt;
  logic [7:0]       gen_byte;
  logic             f_in_ready, f_out_valid, f_out_ready;
  logic [7:0]       f_out_data;
  logic             push;
  logic [15:0]      pkt_last, gap_last;

  // zero lengths behave as one byte / one cycle
  assign pkt_last = (pkt_len_q == 16'h0000) ? 16'h0000 : pkt_len_q - 16'h0001;
  assign gap_last = (gap_len_q == 16'h0000) ? 16'h0000 : gap_len_q - 16'h0001;
  assign push     = (gst_q == ppb_pkg::GEN_PKT) && f_in_ready;

  ppb_lfsr_step #(
    .W (15)
  ) u_gen_step (
    .state_in  (gen_s_q),
    .din       (8'h00),
    .use_din   (1'b0),
    .state_out (gen_s_nxt),
    .dout      (gen_byte)
  );

  // ------------------------------------------------------------
  // packet / gap sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    gst_d   = gst_q;
    gcnt_d  = gcnt_q;
    gen_s_d = gen_s_q;
    case (gst_q)
      ppb_pkg::GEN_IDLE:
      begin
        gcnt_d = 16'h0000;
        if (cont)
          gst_d = ppb_pkg::GEN_PKT;
      end
      ppb_pkg::GEN_PKT:
      begin
        if (push)
        begin
          gen_s_d = gen_s_nxt;
          gcnt_d  = gcnt_q + 16'h0001;
          if (gcnt_q >= pkt_last)
          begin
            gcnt_d = 16'h0000;
            gst_d  = cont ? ppb_pkg::GEN_GAP : ppb_pkg::GEN_IDLE;
          end
        end
      end
      ppb_pkg::GEN_GAP:
      begin
        gcnt_d = gcnt_q + 16'h0001;
        if (gcnt_q >= gap_last)
        begin
          gcnt_d = 16'h0000;
          gst_d  = cont ? ppb_pkg::GEN_PKT : ppb_pkg::GEN_IDLE;
        end
      end
      default:
      begin
        gst_d  = ppb_pkg::GEN_IDLE;
        gcnt_d = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      gst_q   <= ppb_pkg::GEN_IDLE;
      gcnt_q  <= 16'h0000;
      gen_s_q <= ppb_pkg::LFSR_SEED;
    end
    else
    begin
      gst_q   <= gst_d;
      gcnt_q  <= gcnt_d;
      gen_s_q <= gen_s_d;
    end
  end

  // ------------------------------------------------------------
  // transmit buffer and line register
  // ------------------------------------------------------------
  logic       txv_q, txv_d;
  logic [7:0] txd_q, txd_d;
  logic       line_ready;

  // internal loopbacks never stall: the checker always takes the byte
  assign line_ready  = (lb_mode != ppb_pkg::LB_EXTERNAL) || tx_ready;
  assign f_out_ready = !txv_q || line_ready;

  ppb_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (gst_q == ppb_pkg::GEN_PKT),
    .in_ready  (f_in_ready),
    .in_data   (gen_byte),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  always_comb
  begin
    txv_d = txv_q;
    txd_d = txd_q;
    if (f_out_ready)
    begin
      txv_d = f_out_valid;
      txd_d = f_out_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      txv_q <= 1'b0;
      txd_q <= 8'h00;
    end
    else
    begin
      txv_q <= txv_d;
      txd_q <= txd_d;
    end
  end

  // one driver for the whole carrier
  assign tx_line = '{valid: txv_q, data: txd_q};

  // ------------------------------------------------------------
  // checker
  // ------------------------------------------------------------
  logic [14:0]      chk_s_q, chk_s_d, chk_s_nxt;
  logic [7:0]       pred;
  logic             lock_q, lock_d, lost_q, lost_d;
  logic [3:0]       good_q, good_d, bad_q, bad_d;
  logic [15:0]      bcnt_q, bcnt_d;
  logic [ERR_W-1:0] ecnt_q, ecnt_d;
  logic             rv;
  logic [7:0]       rb;
  logic             miss;
  logic             st_rd;

  assign rv    = chk_en_q && ((lb_mode == ppb_pkg::LB_EXTERNAL) ? rx_line.valid : txv_q);
  assign rb    = (lb_mode == ppb_pkg::LB_EXTERNAL) ? rx_line.data : txd_q;
  assign miss  = (rb != pred);
  assign st_rd = mreq.rd && (mreq.addr == ppb_pkg::OFS_STATUS);

  // unlocked: received bits seed the register; locked: it free-runs
  ppb_lfsr_step #(
    .W (15)
  ) u_chk_step (
    .state_in  (chk_s_q),
    .din       (rb),
    .use_din   (!lock_q),
    .state_out (chk_s_nxt),
    .dout      (pred)
  );

  always_comb
  begin
    chk_s_d = chk_s_q;
    lock_d  = lock_q;
    good_d  = good_q;
    bad_d   = bad_q;
    bcnt_d  = bcnt_q;
    ecnt_d  = ecnt_q;
    // a read clears sync loss; a new loss in the same cycle wins
    lost_d  = st_rd ? 1'b0 : lost_q;
    if (rv)
    begin
      chk_s_d = chk_s_nxt;
      if (bcnt_q != 16'hffff)
        bcnt_d = bcnt_q + 16'h0001;
      else if (cont)
        bcnt_d = 16'h0000;
      if (!lock_q)
      begin
        good_d = miss ? 4'h0 : good_q + 4'h1;
        if (!miss && (good_q + 4'h1 >= ppb_pkg::LOCK_BYTES))
        begin
          lock_d = 1'b1;
          bad_d  = 4'h0;
        end
      end
      else if (miss)
      begin
        if (ecnt_q != '1)
          ecnt_d = ecnt_q + ERR_W'(1);
        else if (cont)
          ecnt_d = '0;
        bad_d = bad_q + 4'h1;
        if (bad_q + 4'h1 >= ppb_pkg::LOSS_ERRS)
        begin
          lock_d = 1'b0;
          lost_d = 1'b1;
          good_d = 4'h0;
        end
      end
      else
        bad_d = 4'h0;
    end
    if (clr_cnt)
    begin
      bcnt_d = 16'h0000;
      ecnt_d = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      chk_s_q <= ppb_pkg::LFSR_SEED;
      lock_q  <= 1'b0;
      lost_q  <= 1'b0;
      good_q  <= 4'h0;
      bad_q   <= 4'h0;
      bcnt_q  <= 16'h0000;
      ecnt_q  <= '0;
    end
    else
    begin
      chk_s_q <= chk_s_d;
      lock_q  <= lock_d;
      lost_q  <= lost_d;
      good_q  <= good_d;
      bad_q   <= bad_d;
      bcnt_q  <= bcnt_d;
      ecnt_q  <= ecnt_d;
    end
  end

  // ------------------------------------------------------------
  // management registers
  // ------------------------------------------------------------
  always_comb
  begin
    ctrl_d    = ctrl_q;
    pkt_len_d = pkt_len_q;
    gap_len_d = gap_len_q;
    chk_en_d  = chk_en_q;
    rvalid_d  = mreq.rd;
    rdata_d   = 16'h0000;
    if (mreq.wr)
    begin
      case (mreq.addr)
        ppb_pkg::OFS_CTRL:     ctrl_d    = mreq.wdata;
        ppb_pkg::OFS_PKT_LEN:  pkt_len_d = mreq.wdata;
        ppb_pkg::OFS_GAP_LEN:  gap_len_d = mreq.wdata;
        ppb_pkg::OFS_CHK_CTRL: chk_en_d  = mreq.wdata[ppb_pkg::CHK_EN_BIT];
        default:               ctrl_d    = ctrl_q;
      endcase
    end
    if (mreq.rd)
    begin
      case (mreq.addr)
        ppb_pkg::OFS_CTRL:     rdata_d = ctrl_q;
        ppb_pkg::OFS_STATUS:   rdata_d = {13'h0000, (gst_q != ppb_pkg::GEN_IDLE), lost_q, lock_q};
        ppb_pkg::OFS_PKT_LEN:  rdata_d = pkt_len_q;
        ppb_pkg::OFS_GAP_LEN:  rdata_d = gap_len_q;
        ppb_pkg::OFS_CHK_CTRL: rdata_d = {ecnt_q, 6'h00, chk_en_q, 1'b0};
        ppb_pkg::OFS_BYTE_CNT: rdata_d = bcnt_q;
        default:               rdata_d = 16'h0000;   // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_q    <= ppb_pkg::CTRL_RST;
      pkt_len_q <= ppb_pkg::PKT_LEN_RST;
      gap_len_q <= ppb_pkg::GAP_LEN_RST;
      chk_en_q  <= 1'b0;
      rdata_q   <= 16'h0000;
      rvalid_q  <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      pkt_len_q <= pkt_len_d;
      gap_len_q <= gap_len_d;
      chk_en_q  <= chk_en_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  assign mgmt_rdata  = rdata_q;
  assign mgmt_rvalid = rvalid_q;
  assign lb_mode     = ctrl_q[ppb_pkg::CTRL_LB_LSB +: 2];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_last_byte;
    (gst_q == ppb_pkg::GEN_PKT) && push && (gcnt_q >= pkt_last);
  endsequence

  a_gen_starts: assert property (cont && gst_q == ppb_pkg::GEN_IDLE |=> gst_q == ppb_pkg::GEN_PKT)
    else $error("generator did not start in continuous mode");
  a_gen_halts: assert property (!cont && gst_q == ppb_pkg::GEN_IDLE |=> gst_q == ppb_pkg::GEN_IDLE)
    else $error("generator left idle while disabled");
  a_stop_boundary: assert property (s_last_byte ##0 !cont |=> gst_q == ppb_pkg::GEN_IDLE)
    else $error("generator did not stop at packet end");
  a_pkt_to_gap: assert property (s_last_byte ##0 cont |=> gst_q == ppb_pkg::GEN_GAP && gcnt_q == 16'h0000)
    else $error("no gap after packet");
  a_pkt_holds: assert property (gst_q == ppb_pkg::GEN_PKT && gcnt_q < pkt_last && cont |=> gst_q == ppb_pkg::GEN_PKT)
    else $error("packet ended early");
  a_gap_holds: assert property (gst_q == ppb_pkg::GEN_GAP && gcnt_q < gap_last |=> gst_q == ppb_pkg::GEN_GAP)
    else $error("gap ended early");
  a_lfsr_live: assert property (push |=> gen_s_q != $past(gen_s_q) && gen_s_q != 15'h0000)
    else $error("sequence register stuck");
  a_err_count: assert property (rv && lock_q && miss && !clr_cnt && ecnt_q != '1 |=> ecnt_q == $past(ecnt_q) + ERR_W'(1))
    else $error("error byte not counted");
  a_byte_count: assert property (rv && !clr_cnt && bcnt_q != 16'hffff |=> bcnt_q == $past(bcnt_q) + 16'h0001)
    else $error("received byte not counted");
  a_cnt_wrap: assert property (rv && cont && !clr_cnt && bcnt_q == 16'hffff |=> bcnt_q == 16'h0000)
    else $error("counter did not wrap");
  a_cnt_sat: assert property (rv && !cont && !clr_cnt && bcnt_q == 16'hffff |=> bcnt_q == 16'hffff)
    else $error("counter did not saturate");
  a_sync_loss: assert property (rv && lock_q && miss && bad_q == ppb_pkg::LOSS_ERRS - 4'h1 |=> !lock_q && lost_q)
    else $error("sync loss not reported");
  a_lock_gain: assert property (rv && !lock_q && !miss && good_q == ppb_pkg::LOCK_BYTES - 4'h1 |=> lock_q)
    else $error("checker failed to lock");

endmodule : ppb_bist

`default_nettype wire

/* File: dv/ppb_loop_model.sv */
// stand-in for the external cable fixture on the self test line
// assumes one clock; the bench drives the stall and flip requests
`default_nettype none

module ppb_loop_model (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire ppb_pkg::ppb_line_s tx_line,
  output logic                    tx_ready,
  output ppb_pkg::ppb_line_s      rx_line,
  input  wire logic               stall,
  input  wire logic [2:0]         flip_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] flips_q;
  logic       take;

  assign take = tx_line.valid && tx_ready;

  // ------------------------------------------------
  // cable return path
  // ------------------------------------------------
  // byte returns one cycle later
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tx_ready <= 1'b0;
      rx_line  <= '0;
      flips_q  <= 3'h0;
    end
    else
    begin
      tx_ready      <= !stall;
      rx_line.valid <= take;
      // idle data toggles so a stale byte never looks valid
      rx_line.data  <= take ? tx_line.data ^ {7'h00, flips_q != 3'h0} : ~rx_line.data;
      if (flip_n != 3'h0)
        flips_q <= flip_n;
      else if (take && flips_q != 3'h0)
        flips_q <= flips_q - 3'h1;
    end
  end

endmodule : ppb_loop_model

`default_nettype wire

/* File: dv/test_phy_prbs_bist.sv */
// self-checking bench for the pseudo-random self test block
// assumes the cable model in ppb_loop_model and the package constants
`default_nettype none

module test_phy_prbs_bist;
  timeunit 1ns;
  timeprecision 1ps;

  logic               sys_clk     = 1'b0;
  logic               rst_n       = 1'b0;
  ppb_pkg::ppb_mreq_s mreq        = '0;
  logic [15:0]        mgmt_rdata;
  logic               mgmt_rvalid;
  ppb_pkg::ppb_line_s tx_line;
  ppb_pkg::ppb_line_s rx_line;
  logic               tx_ready;
  logic [1:0]         lb_mode;
  logic               stall       = 1'b0;
  logic [2:0]         flip_n      = 3'h0;
  logic [15:0]        exp_q[$];
  logic [15:0]        rx_cnt      = 16'h0000;
  logic [31:0]        rng         = 32'h0000_30cc;
  logic [14:0]        hist        = '0;
  logic               bit_v;
  logic               par;
  logic               par0;
  logic               rnd_on      = 1'b0;
  logic               gap_chk     = 1'b0;
  int                 nbits       = 0;
  int                 run_v       = 0;
  int                 run_g       = 0;
  int                 n_fail      = 0;
  int                 check_count = 0;

  always #12.5 sys_clk = ~sys_clk;

  ppb_bist #(.FIFO_DEPTH(8), .ERR_W(8)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .mreq(mreq), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .tx_line(tx_line), .tx_ready(tx_ready),
    .rx_line(rx_line), .lb_mode(lb_mode));

  ppb_loop_model loop_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .tx_line(tx_line), .tx_ready(tx_ready),
    .rx_line(rx_line), .stall(stall), .flip_n(flip_n));

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    mreq <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    mreq <= '0;
  endtask : wr

  // expectation goes on the queue before the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    mreq <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge sys_clk);
    mreq <= '0;
  endtask : rd

  task automatic flip(input logic [2:0] k);
    @(posedge sys_clk);
    flip_n <= k;
    @(posedge sys_clk);
    flip_n <= 3'h0;
    repeat (60) @(posedge sys_clk);
  endtask : flip

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  // ------------------------------------------------
  // monitors
  // ------------------------------------------------
  // read answers against the oldest note
  always @(posedge sys_clk)
  begin
    if (mgmt_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(mgmt_rdata, 16'hxxxx, "unasked read");
      else
        chk(mgmt_rdata, exp_q.pop_front(), "read data");
    end
  end

  // stream bits must obey one fixed 15-stage recurrence, either polarity
  always @(posedge sys_clk)
  begin
    // bytes the checker sees: returned line, or the line itself on internal loopback
    if ((lb_mode === 2'h0) ? (rx_line.valid === 1'b1) : (tx_line.valid === 1'b1))
      rx_cnt <= rx_cnt + 16'h0001;
    if (tx_line.valid === 1'b1 && tx_ready === 1'b1 && lb_mode === 2'h0)
      for (int i = 7; i >= 0; i--)
      begin
        bit_v = tx_line.data[i];
        par = bit_v ^ hist[13] ^ hist[14];
        if (nbits == 15)
          par0 = par;
        else if (nbits > 15)
          chk({15'h0, par}, {15'h0, par0}, "sequence bit");
        hist = {hist[13:0], bit_v};
        nbits++;
      end
    if (gap_chk && tx_line.valid === 1'b1)
    begin
      if (run_g > 0 && run_v > 0)
      begin
        chk(16'(run_v), 16'h0004, "packet length");
        chk(16'(run_g), 16'h0003, "gap length");
        run_v = 0;
      end
      run_g = 0;
      run_v++;
    end
    else if (gap_chk)
      run_g++;
  end

  // random line stalls, about one cycle in eight
  always @(posedge sys_clk)
  begin
    if (rnd_on)
    begin
      rng = xs(rng);
      stall <= rng[2:0] == 3'h0;
    end
  end

  // ------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ppb_pkg::OFS_CTRL, ppb_pkg::CTRL_RST);
    rd(ppb_pkg::OFS_STATUS, 16'h0000);
    rd(ppb_pkg::OFS_PKT_LEN, ppb_pkg::PKT_LEN_RST);
    rd(ppb_pkg::OFS_GAP_LEN, ppb_pkg::GAP_LEN_RST);
    rd(ppb_pkg::OFS_CHK_CTRL, 16'h0000);
    rd(ppb_pkg::OFS_BYTE_CNT, 16'h0000);
    rd(8'h20, 16'h0000);
    for (int m = 2; m >= 0; m--)
    begin
      wr(ppb_pkg::OFS_CTRL, 16'(m) << ppb_pkg::CTRL_LB_LSB);
      repeat (2) @(posedge sys_clk);
      chk({14'h0, lb_mode}, 16'(m), "loopback select");
    end
    $display("test reset and loopback select done");
    wr(ppb_pkg::OFS_PKT_LEN, 16'h0004);
    wr(ppb_pkg::OFS_GAP_LEN, 16'h0003);
    wr(ppb_pkg::OFS_CHK_CTRL, 16'h0002);
    gap_chk = 1'b1;
    wr(ppb_pkg::OFS_CTRL, {ppb_pkg::GEN_CONT, 12'h000});
    repeat (300) @(posedge sys_clk);
    gap_chk = 1'b0;
    rd(ppb_pkg::OFS_STATUS, 16'h0005);
    $display("test packet framing done");
    rnd_on = 1'b1;
    wr(ppb_pkg::OFS_PKT_LEN, 16'h0100);
    wr(ppb_pkg::OFS_GAP_LEN, 16'h0002);
    flip(3'h1);
    flip(3'h1);
    rd(ppb_pkg::OFS_CHK_CTRL, 16'h0202);
    flip(3'h4);
    repeat (60) @(posedge sys_clk);
    rd(ppb_pkg::OFS_STATUS, 16'h0007);
    rd(ppb_pkg::OFS_STATUS, 16'h0005);
    rd(ppb_pkg::OFS_CHK_CTRL, 16'h0602);
    $display("test error injection done");
    repeat (80000) @(posedge sys_clk);
    wr(ppb_pkg::OFS_CTRL, 16'h0000);
    repeat (400) @(posedge sys_clk);
    rd(ppb_pkg::OFS_STATUS, 16'h0001);
    rd(ppb_pkg::OFS_BYTE_CNT, rx_cnt);
    wr(ppb_pkg::OFS_CHK_CTRL, 16'h0003);
    rd(ppb_pkg::OFS_BYTE_CNT, 16'h0000);
    rd(ppb_pkg::OFS_CHK_CTRL, 16'h0002);
    $display("test wrap, stop and clear done");
    // internal loopback: checker follows the line itself, stream stays in step
    rx_cnt <= 16'h0000;
    wr(ppb_pkg::OFS_CTRL, {ppb_pkg::GEN_CONT, ppb_pkg::LB_DIGITAL, 10'h000});
    repeat (300) @(posedge sys_clk);
    wr(ppb_pkg::OFS_CTRL, {4'h0, ppb_pkg::LB_ANALOG, 10'h000});
    repeat (400) @(posedge sys_clk);
    rd(ppb_pkg::OFS_STATUS, 16'h0001);
    rd(ppb_pkg::OFS_BYTE_CNT, rx_cnt);
    rd(ppb_pkg::OFS_CHK_CTRL, 16'h0002);
    repeat (4) @(posedge sys_clk);
    chk(16'(exp_q.size()), 16'h0000, "reads unanswered");
    $display("test internal loopback done");
    end_sim();
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

endmodule : test_phy_prbs_bist

`default_nettype wire
